// ### common/exec_unit_pkg.sv
// Shared constants and types for the instruction execute unit subset
package exec_unit_pkg;

  // Datapath widths
  localparam int DATA_W = 8;           // Data byte width
  localparam int DMEM_DEPTH = 64;      // Data memory bytes
  localparam int DMEM_AW = 6;          // Data memory address width
  localparam int PROG_W = 14;          // Program word width
  localparam int PROG_AW = 10;         // Program memory address width
  localparam int PAGE_W = 2;           // Page bits above the table pointer
  localparam int HIGH_W = PROG_W - DATA_W; // Width of the table high latch

  // Avalon-MM slave geometry, byte addresses
  localparam int BUS_AW = 9;
  localparam logic [BUS_AW-1:0] OFS_INSTR = 9'h000;  // Write issues one instruction
  localparam logic [BUS_AW-1:0] OFS_WORK = 9'h004;   // Working register
  localparam logic [BUS_AW-1:0] OFS_FLAGS = 9'h008;  // Status flags
  localparam logic [BUS_AW-1:0] OFS_TPTR = 9'h00C;   // Table pointer
  localparam logic [BUS_AW-1:0] OFS_THIGH = 9'h010;  // Table high latch, read only
  localparam logic [BUS_AW-1:0] OFS_SKIP = 9'h014;   // Skip status, read only
  localparam logic [BUS_AW-1:0] OFS_DMEM = 9'h100;   // Data memory window base
  localparam int WORD_LSB = 2;                       // Byte address to word index shift

  // Instruction word fields written to OFS_INSTR
  localparam int OP_LSB = 0;
  localparam int OP_W = 5;
  localparam int BIT_LSB = 8;
  localparam int BIT_W = 3;
  localparam int MADDR_LSB = 16;
  localparam int IMM_LSB = 24;

  // Flag positions in OFS_FLAGS
  localparam int FLAG_NULL = 0;        // result_null_flag
  localparam int FLAG_BORROW = 1;      // borrow_out_bit
  localparam int FLAG_HALF = 2;        // half_borrow_bit
  localparam int FLAG_RANGE = 3;       // signed_range_error_bit

  // Skip status fields in OFS_SKIP
  localparam int SKIP_LAST = 0;
  localparam int SKIP_CNT_LSB = 8;

  // Reset values and fixed constants
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
  localparam logic [DATA_W-1:0] BYTE_ALL_ONES = 8'hFF;
  localparam logic [PAGE_W-1:0] LAST_PAGE = 2'h3;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // Instruction codes carried in the op field
  typedef enum logic [OP_W-1:0] {
    OP_NOP,
    OP_BYTE_SET,
    OP_BIT_SET,
    OP_INCREMENT_SKIP_NULL,
    OP_INCREMENT_TO_WORKING_SKIP,
    OP_DECREMENT_TO_WORKING_SKIP,
    OP_BIT_SET_SKIP,
    OP_BIT_CLEAR_SKIP,
    OP_TEST_SKIP_IF_NULL,
    OP_COPY_TEST_SKIP,
    OP_SUBTRACT_TO_WORKING,
    OP_SUBTRACT_TO_MEMORY,
    OP_SUBTRACT_IMMEDIATE,
    OP_NIBBLE_SWAP,
    OP_NIBBLE_EXCHANGE_TO_WORKING,
    OP_TABLE_READ_CURRENT_PAGE,
    OP_TABLE_READ_LAST_PAGE,
    OP_EXCLUSIVE_OR_TO_WORKING,
    OP_EXCLUSIVE_OR_TO_MEMORY,
    OP_EXCLUSIVE_OR_IMMEDIATE
  } op_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_EXEC,
    ST_DUMMY,
    ST_ACK
  } state_t;

endpackage

// ### design/data_byte_ram.sv
// Data memory bytes with one write port and a registered read port
`timescale 1ns/1ps
module data_byte_ram #(
  parameter int DATA_W = 8,
  parameter int DEPTH = 64,
  parameter int AW = 6
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);

  // Refuse a depth the address cannot reach
  if (DEPTH > (1 << AW) || DEPTH < 2)
  begin
    $error("data_byte_ram: DEPTH does not fit AW");
  end

  // Storage array, left uninitialised like real RAM
  logic [DATA_W-1:0] cells [DEPTH];

  // Write port
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      cells[wr_addr] <= wr_data;
    end
  end

  // Read data register; old contents are returned on a same-address write
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_data <= '0;
    end
    else
    begin
      rd_data <= cells[rd_addr];
    end
  end

endmodule

// ### design/mcu_execute_unit_subset.sv
// Execute unit for a subset of an 8-bit controller instruction set, Avalon-MM driven
// How it works
// - Byte set writes all ones, flags kept
// - Bit set forces chosen bit to one
// - True skip discards prefetch, adds dummy cycle
// - Increment byte in place, skip if zero
// - Increment into working register, skip if zero
// - Decrement into working register, skip if zero
// - Skip when selected bit is one
// - Skip when selected bit is zero
// - Skip when whole byte is zero
// - Copy byte to working, skip if zero
// - Working minus byte into working, four flags
// - Working minus byte into memory, four flags
// - Working minus constant into working, four flags
// - Swap nibbles of byte in place
// - Swapped byte into working, memory kept
// - Table read, current page, low and high
// - Table read, last page, low and high
// - Working xor byte into working, null flag
// - Working xor byte into memory, null flag
// - Working xor constant into working, null flag
`timescale 1ns/1ps
module mcu_execute_unit_subset
  import exec_unit_pkg::*;
#(
  parameter int DMEM_BYTES = exec_unit_pkg::DMEM_DEPTH
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [exec_unit_pkg::BUS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [exec_unit_pkg::PAGE_W-1:0] current_page,
  output logic [exec_unit_pkg::PROG_AW-1:0] prog_addr,
  output logic prog_rd,
  input wire logic [exec_unit_pkg::PROG_W-1:0] prog_data,
  output logic discard_prefetch
);
  import exec_unit_pkg::*;

  // The data memory address field is fixed at six bits
  if (DMEM_BYTES > DMEM_DEPTH || DMEM_BYTES < 2)
  begin
    $error("mcu_execute_unit_subset: DMEM_BYTES out of range");
  end

  // Sequencer and latched request
  state_t state;
  state_t next_state;
  logic [BUS_AW-1:0] req_addr;       // Byte address of the held request
  logic req_write;                   // Held request is a write
  logic req_lane0;                   // Low byte lane enabled on the write
  logic [31:0] req_wdata;            // Held write data
  logic [DMEM_AW-1:0] req_maddr;     // Data memory byte this request touches

  // Architectural state
  logic [DATA_W-1:0] working_register;
  logic result_null_flag;
  logic borrow_out_bit;
  logic half_borrow_bit;
  logic signed_range_error_bit;
  logic [DATA_W-1:0] table_pointer;
  logic [HIGH_W-1:0] table_high_latch;
  logic last_skip;                   // Last instruction skipped
  logic [DATA_W-1:0] skip_count;     // Dummy cycles inserted, wraps

  // Next values
  logic [DATA_W-1:0] next_working_register;
  logic next_result_null_flag;
  logic next_borrow_out_bit;
  logic next_half_borrow_bit;
  logic next_signed_range_error_bit;
  logic [DATA_W-1:0] next_table_pointer;
  logic [HIGH_W-1:0] next_table_high_latch;
  logic next_skip;                   // Condition of the executing instruction
  logic [31:0] next_readdata;

  // Memory write request from execution or from the bus window
  logic mem_we;
  logic [DATA_W-1:0] mem_wdata;
  logic [DATA_W-1:0] mem_rdata;

  // Incoming request decode, used only while idle
  wire bus_req = avs_read || avs_write;
  wire bus_instr = avs_write && (avs_address == OFS_INSTR);
  wire [DMEM_AW-1:0] bus_word = avs_address[WORD_LSB +: DMEM_AW];
  wire [DMEM_AW-1:0] instr_maddr = avs_writedata[MADDR_LSB +: DMEM_AW];
  wire [DMEM_AW-1:0] idle_maddr = bus_instr ? instr_maddr : bus_word;

  // Read address is steered straight from the bus while idle so data is ready in LOAD
  wire [DMEM_AW-1:0] mem_raddr = (state == ST_IDLE) ? idle_maddr : req_maddr;

  // Held request decode
  wire op_issue = req_write && (req_addr == OFS_INSTR);
  // Compare one bit wider so that a full 64-byte depth does not wrap to zero
  wire dmem_hit = (req_addr >= OFS_DMEM)
    && ({1'b0, req_addr[WORD_LSB +: DMEM_AW]} < (DMEM_AW + 1)'(DMEM_BYTES));
  wire op_t op = op_t'(req_wdata[OP_LSB +: OP_W]);
  wire [BIT_W-1:0] bit_index = req_wdata[BIT_LSB +: BIT_W];
  wire [DATA_W-1:0] immediate = req_wdata[IMM_LSB +: DATA_W];

  // Operand shaping
  wire [DATA_W-1:0] bit_mask = BYTE_ONE << bit_index;
  wire selected_bit = |(mem_rdata & bit_mask);
  wire [DATA_W-1:0] inc_value = mem_rdata + BYTE_ONE;
  wire [DATA_W-1:0] dec_value = mem_rdata - BYTE_ONE;
  wire [DATA_W-1:0] swapped = {mem_rdata[3:0], mem_rdata[7:4]};
  wire [DATA_W-1:0] xor_operand = (op == OP_EXCLUSIVE_OR_IMMEDIATE) ? immediate : mem_rdata;
  wire [DATA_W-1:0] xor_value = working_register ^ xor_operand;
  wire xor_null = (xor_value == BYTE_ZERO);

  // Subtraction as working plus inverted operand plus one
  wire [DATA_W-1:0] sub_operand = (op == OP_SUBTRACT_IMMEDIATE) ? immediate : mem_rdata;
  wire [DATA_W-1:0] sub_inverted = ~sub_operand;
  wire [DATA_W:0] sub_sum = {1'b0, working_register} + {1'b0, sub_inverted}
    + {{DATA_W{1'b0}}, 1'b1};
  wire [4:0] sub_low = {1'b0, working_register[3:0]} + {1'b0, sub_inverted[3:0]} + 5'h01;
  wire [DATA_W-1:0] sub_value = sub_sum[DATA_W-1:0];
  wire sub_carry = sub_sum[DATA_W];
  wire sub_half = sub_low[4];
  // Overflow: operands of equal sign give a result of the other sign
  wire sub_range = (working_register[7] == sub_inverted[7])
    && (sub_value[7] != working_register[7]);
  wire sub_null = (sub_value == BYTE_ZERO);

  // Table address: page bits above the pointer
  wire [PAGE_W-1:0] table_page = (bus_instr
    && (op_t'(avs_writedata[OP_LSB +: OP_W]) == OP_TABLE_READ_LAST_PAGE))
    ? LAST_PAGE : current_page;
  wire table_op = bus_instr
    && ((op_t'(avs_writedata[OP_LSB +: OP_W]) == OP_TABLE_READ_CURRENT_PAGE)
    || (op_t'(avs_writedata[OP_LSB +: OP_W]) == OP_TABLE_READ_LAST_PAGE));

  // Flag register image
  wire [3:0] flag_image = {signed_range_error_bit, half_borrow_bit,
    borrow_out_bit, result_null_flag};

  // Data memory
  data_byte_ram #(
    .DATA_W(DATA_W),
    .DEPTH(DMEM_BYTES),
    .AW(DMEM_AW)
  ) u_dmem (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(mem_we),
    .wr_addr(req_maddr),
    .wr_data(mem_wdata),
    .rd_addr(mem_raddr),
    .rd_data(mem_rdata)
  );

  // Instruction execution and bus register writes; all state defaults to hold
  always_comb
  begin
    next_working_register = working_register;
    next_result_null_flag = result_null_flag;
    next_borrow_out_bit = borrow_out_bit;
    next_half_borrow_bit = half_borrow_bit;
    next_signed_range_error_bit = signed_range_error_bit;
    next_table_pointer = table_pointer;
    next_table_high_latch = table_high_latch;
    next_skip = 1'b0;
    mem_we = 1'b0;
    mem_wdata = mem_rdata;
    if (state == ST_EXEC)
    begin
      // Memory operand is valid now; flags move only where listed
      case (op)
        OP_BYTE_SET:
        begin
          mem_we = 1'b1;
          mem_wdata = BYTE_ALL_ONES;
        end
        OP_BIT_SET:
        begin
          mem_we = 1'b1;
          mem_wdata = mem_rdata | bit_mask;
        end
        OP_INCREMENT_SKIP_NULL:
        begin
          mem_we = 1'b1;
          mem_wdata = inc_value;
          next_skip = (inc_value == BYTE_ZERO);
        end
        OP_INCREMENT_TO_WORKING_SKIP:
        begin
          next_working_register = inc_value;
          next_skip = (inc_value == BYTE_ZERO);
        end
        OP_DECREMENT_TO_WORKING_SKIP:
        begin
          next_working_register = dec_value;
          next_skip = (dec_value == BYTE_ZERO);
        end
        OP_BIT_SET_SKIP:
        begin
          next_skip = selected_bit;
        end
        OP_BIT_CLEAR_SKIP:
        begin
          next_skip = !selected_bit;
        end
        OP_TEST_SKIP_IF_NULL:
        begin
          next_skip = (mem_rdata == BYTE_ZERO);
        end
        OP_COPY_TEST_SKIP:
        begin
          next_working_register = mem_rdata;
          next_skip = (mem_rdata == BYTE_ZERO);
        end
        OP_SUBTRACT_TO_WORKING, OP_SUBTRACT_IMMEDIATE:
        begin
          next_working_register = sub_value;
          next_result_null_flag = sub_null;
          next_borrow_out_bit = sub_carry;
          next_half_borrow_bit = sub_half;
          next_signed_range_error_bit = sub_range;
        end
        OP_SUBTRACT_TO_MEMORY:
        begin
          mem_we = 1'b1;
          mem_wdata = sub_value;
          next_result_null_flag = sub_null;
          next_borrow_out_bit = sub_carry;
          next_half_borrow_bit = sub_half;
          next_signed_range_error_bit = sub_range;
        end
        OP_NIBBLE_SWAP:
        begin
          mem_we = 1'b1;
          mem_wdata = swapped;
        end
        OP_NIBBLE_EXCHANGE_TO_WORKING:
        begin
          next_working_register = swapped;
        end
        OP_TABLE_READ_CURRENT_PAGE, OP_TABLE_READ_LAST_PAGE:
        begin
          // Program word arrives one cycle after the fetch strobe
          mem_we = 1'b1;
          mem_wdata = prog_data[DATA_W-1:0];
          next_table_high_latch = prog_data[PROG_W-1:DATA_W];
        end
        OP_EXCLUSIVE_OR_TO_WORKING, OP_EXCLUSIVE_OR_IMMEDIATE:
        begin
          next_working_register = xor_value;
          next_result_null_flag = xor_null;
        end
        OP_EXCLUSIVE_OR_TO_MEMORY:
        begin
          mem_we = 1'b1;
          mem_wdata = xor_value;
          next_result_null_flag = xor_null;
        end
        default:
        begin
          // Unknown codes execute as a one-cycle no-operation
          next_skip = 1'b0;
        end
      endcase
    end
    else if (state == ST_LOAD && req_write && req_lane0)
    begin
      // Software writes land in the low byte lane only
      if (req_addr == OFS_WORK)
      begin
        next_working_register = req_wdata[DATA_W-1:0];
      end
      else if (req_addr == OFS_FLAGS)
      begin
        next_result_null_flag = req_wdata[FLAG_NULL];
        next_borrow_out_bit = req_wdata[FLAG_BORROW];
        next_half_borrow_bit = req_wdata[FLAG_HALF];
        next_signed_range_error_bit = req_wdata[FLAG_RANGE];
      end
      else if (req_addr == OFS_TPTR)
      begin
        next_table_pointer = req_wdata[DATA_W-1:0];
      end
      else if (dmem_hit)
      begin
        mem_we = 1'b1;
        mem_wdata = req_wdata[DATA_W-1:0];
      end
    end
  end

  // Read data mux; unmapped addresses answer zero
  always_comb
  begin
    next_readdata = READ_ZERO;
    if (req_addr == OFS_WORK)
    begin
      next_readdata[DATA_W-1:0] = working_register;
    end
    else if (req_addr == OFS_FLAGS)
    begin
      next_readdata[3:0] = flag_image;
    end
    else if (req_addr == OFS_TPTR)
    begin
      next_readdata[DATA_W-1:0] = table_pointer;
    end
    else if (req_addr == OFS_THIGH)
    begin
      next_readdata[HIGH_W-1:0] = table_high_latch;
    end
    else if (req_addr == OFS_SKIP)
    begin
      next_readdata[SKIP_LAST] = last_skip;
      next_readdata[SKIP_CNT_LSB +: DATA_W] = skip_count;
    end
    else if (dmem_hit)
    begin
      next_readdata[DATA_W-1:0] = mem_rdata;
    end
  end

  // Sequencer: idle, load operand, execute, optional dummy, answer
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        next_state = bus_req ? ST_LOAD : ST_IDLE;
      end
      ST_LOAD:
      begin
        next_state = op_issue ? ST_EXEC : ST_ACK;
      end
      ST_EXEC:
      begin
        next_state = next_skip ? ST_DUMMY : ST_ACK;
      end
      ST_DUMMY:
      begin
        next_state = ST_ACK;
      end
      ST_ACK:
      begin
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Request capture while idle; held until the answer
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      req_addr <= '0;
      req_write <= 1'b0;
      req_lane0 <= 1'b0;
      req_wdata <= '0;
      req_maddr <= '0;
    end
    else if (state == ST_IDLE && bus_req)
    begin
      req_addr <= avs_address;
      req_write <= avs_write;
      req_lane0 <= avs_byteenable[0];
      req_wdata <= avs_writedata;
      req_maddr <= idle_maddr;
    end
  end

  // Architectural registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      working_register <= BYTE_ZERO;
      result_null_flag <= 1'b0;
      borrow_out_bit <= 1'b0;
      half_borrow_bit <= 1'b0;
      signed_range_error_bit <= 1'b0;
      table_pointer <= BYTE_ZERO;
      table_high_latch <= '0;
    end
    else
    begin
      working_register <= next_working_register;
      result_null_flag <= next_result_null_flag;
      borrow_out_bit <= next_borrow_out_bit;
      half_borrow_bit <= next_half_borrow_bit;
      signed_range_error_bit <= next_signed_range_error_bit;
      table_pointer <= next_table_pointer;
      table_high_latch <= next_table_high_latch;
    end
  end

  // Skip bookkeeping; the discard pulse covers exactly the dummy cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      last_skip <= 1'b0;
      skip_count <= BYTE_ZERO;
      discard_prefetch <= 1'b0;
    end
    else
    begin
      discard_prefetch <= (state == ST_EXEC) && next_skip;
      if (state == ST_EXEC)
      begin
        last_skip <= next_skip;
        skip_count <= skip_count + (next_skip ? BYTE_ONE : BYTE_ZERO);
      end
    end
  end

  // Program memory fetch, launched with the request so the word lands in EXEC
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prog_addr <= '0;
      prog_rd <= 1'b0;
    end
    else
    begin
      prog_rd <= (state == ST_IDLE) && table_op;
      if ((state == ST_IDLE) && table_op)
      begin
        prog_addr <= {table_page, table_pointer};
      end
    end
  end

  // Bus answer: waitrequest drops for the single answer cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= READ_ZERO;
    end
    else
    begin
      avs_waitrequest <= (next_state != ST_ACK);
      if (state == ST_LOAD && !req_write)
      begin
        avs_readdata <= next_readdata;
      end
    end
  end

endmodule

// ### verif/prog_mem_model.sv
// Behavioural program memory answering table fetches of the execute unit
`timescale 1ns/1ps
module prog_mem_model
(
  input wire logic clk,
  input wire logic prog_rd,
  input wire logic [exec_unit_pkg::PROG_AW-1:0] prog_addr,
  output logic [exec_unit_pkg::PROG_W-1:0] prog_data
);
  import exec_unit_pkg::*;
  initial prog_data = 14'h0000;
  // Word is valid only in the cycle after the strobe; otherwise the bus churns
  // so that a late sample cannot pass by luck
  always @(posedge clk)
  begin
    if (prog_rd)
      prog_data <= {prog_addr[9:4] ^ 6'h2A, prog_addr[7:0] ^ 8'h5A};
    else
      prog_data <= ~prog_data;
  end
endmodule

// ### verif/mcu_execute_unit_subset_chk.sv
// Port-level timing checks for the execute unit subset
`timescale 1ns/1ps
module mcu_execute_unit_subset_chk
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [exec_unit_pkg::BUS_AW-1:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic [exec_unit_pkg::PAGE_W-1:0] current_page,
  input wire logic [exec_unit_pkg::PROG_AW-1:0] prog_addr,
  input wire logic prog_rd,
  input wire logic discard_prefetch
);
  import exec_unit_pkg::*;
  // Opcode field of the word on the bus
  wire [4:0] op = avs_writedata[4:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Instruction issue leaving idle
  sequence s_issue;
    $rose(avs_write) && avs_address == OFS_INSTR;
  endsequence
  // Issue of an opcode that never skips
  sequence s_plain;
    s_issue ##0 (op < 5'h03 || op > 5'h09);
  endsequence
  property p_issue_answer;
    s_issue |-> ##3 (avs_waitrequest == discard_prefetch);
  endproperty
  a_issue_answer: assert property (p_issue_answer)
    else $error("issue answer or dummy cycle misplaced");
  property p_dummy;
    discard_prefetch |=> !avs_waitrequest && !discard_prefetch;
  endproperty
  a_dummy: assert property (p_dummy)
    else $error("dummy cycle not one cycle before answer");
  property p_plain;
    s_plain |-> ##3 !avs_waitrequest;
  endproperty
  a_plain: assert property (p_plain)
    else $error("non-skip instruction took extra cycle");
  property p_cur_page;
    s_issue ##0 op == 5'h0F |=> prog_rd && prog_addr[9:8] == $past(current_page);
  endproperty
  a_cur_page: assert property (p_cur_page)
    else $error("current page fetch wrong");
  property p_last_page;
    s_issue ##0 op == 5'h10 |=> prog_rd && prog_addr[9:8] == LAST_PAGE;
  endproperty
  a_last_page: assert property (p_last_page)
    else $error("last page fetch wrong");
  property p_fetch_pulse;
    prog_rd |=> !prog_rd;
  endproperty
  a_fetch_pulse: assert property (p_fetch_pulse)
    else $error("fetch strobe longer than one cycle");
  property p_no_fetch;
    s_issue ##0 (op != 5'h0F && op != 5'h10) |=> !prog_rd [*2];
  endproperty
  a_no_fetch: assert property (p_no_fetch)
    else $error("fetch without table read");
  property p_wait_one;
    $fell(avs_waitrequest) |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("answer longer than one cycle");
endmodule
bind mcu_execute_unit_subset mcu_execute_unit_subset_chk i_chk (.clk(clk), .rst_b(rst_b),
  .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .current_page(current_page), .prog_addr(prog_addr),
  .prog_rd(prog_rd), .discard_prefetch(discard_prefetch));

// ### verif/tb_mcu_execute_unit_subset.sv
// Random instruction stream checked against an integer model
`timescale 1ns/1ps
module tb_mcu_execute_unit_subset;
  import exec_unit_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [BUS_AW-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [PAGE_W-1:0] current_page = '0;
  logic [PROG_AW-1:0] prog_addr;
  logic prog_rd;
  logic [PROG_W-1:0] prog_data;
  logic discard_prefetch;
  int failures = 0;
  int check_count = 0;
  int seed = 32'hFE58E334;
  int mem[64]; // Model of the data bytes
  int w, f, tp, th, sc, sk, pg, i, op, b, m, imm, v, o, s, r, x, a, n;
  logic [31:0] q; // Last read data
  always #5 clk = ~clk;
  mcu_execute_unit_subset i_dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .current_page(current_page), .prog_addr(prog_addr),
    .prog_rd(prog_rd), .prog_data(prog_data), .discard_prefetch(discard_prefetch));
  prog_mem_model i_mem (.clk(clk), .prog_rd(prog_rd), .prog_addr(prog_addr),
    .prog_data(prog_data));
  task automatic print_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One Avalon transfer; n counts rising edges up to the answer, bounded
  task automatic bus(input logic wr, input int ad, input int d);
    @(posedge clk);
    avs_write <= wr;
    avs_read <= ~wr;
    avs_address <= BUS_AW'(ad);
    avs_writedata <= d;
    n = 0;
    // Waitrequest is sampled at the rising edge, where the answer counts
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0)
    begin
      failures++;
      print_verdict();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  initial
  begin
    {w, f, tp, th, sc} = '0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values, then an unmapped place that reads zero
    for (i = 1; i < 7; i++)
    begin
      bus(1'b0, i * 4, 0);
      chk("reset", 0, q);
    end
    for (i = 0; i < 64; i++)
    begin
      mem[i] = i * 37 % 256;
      bus(1'b1, OFS_DMEM + i * 4, mem[i]);
    end
    // Each pass: seed operands, issue one op, compare working, flags, high latch, skip status and the operand byte
    for (i = 0; i < 400; i++)
    begin
      op = i % 20;
      m = {$random(seed)} % 64;
      b = {$random(seed)} % 8;
      imm = {$random(seed)} % 256;
      pg = {$random(seed)} % 4;
      v = {$random(seed)} % 4;
      // Biased towards values that wrap to zero
      mem[m] = (v == 0) ? 0 : (v == 1) ? 255 : (v == 2) ? 1 : {$random(seed)} % 256;
      w = {$random(seed)} % 256;
      f = {$random(seed)} % 16;
      tp = {$random(seed)} % 256;
      current_page <= PAGE_W'(pg);
      bus(1'b1, OFS_DMEM + m * 4, mem[m]);
      bus(1'b1, OFS_WORK, w);
      bus(1'b1, OFS_FLAGS, f);
      bus(1'b1, OFS_TPTR, tp);
      v = mem[m];
      o = (op == 12 || op == 19) ? imm : v;
      s = w + (255 - o) + 1;
      r = s & 255;
      x = w ^ o;
      a = ((op == 16 ? 3 : pg) << 8) + tp;
      if (op >= 10 && op <= 12)
        f = ((w ^ r) & ((255 - o) ^ r) & 128) / 16 + ((w & 15) >= (o & 15)) * 4
          + (s >> 8) * 2 + (r == 0);
      if (op >= 17)
        f = (f & 14) + (x == 0);
      case (op)
        1: mem[m] = 255;
        2: mem[m] = v | (1 << b);
        3: mem[m] = (v + 1) & 255;
        4: w = (v + 1) & 255;
        5: w = (v + 255) & 255;
        9: w = v;
        10, 12: w = r;
        11: mem[m] = r;
        13: mem[m] = {v[3:0], v[7:4]};
        14: w = {v[3:0], v[7:4]};
        15, 16:
        begin
          mem[m] = (a ^ 90) & 255;
          th = ((a >> 4) & 63) ^ 42;
        end
        17, 19: w = x;
        18: mem[m] = x;
        default: ;
      endcase
      case (op)
        3: sk = (mem[m] == 0);
        4, 5, 9: sk = (w == 0);
        6: sk = v[b];
        7: sk = !v[b];
        8: sk = (v == 0);
        default: sk = 0;
      endcase
      sc = (sc + sk) & 255;
      bus(1'b1, OFS_INSTR, (imm << 24) + (m << 16) + (b << 8) + op);
      chk("cycles", sk ? 5 : 4, n);
      bus(1'b0, OFS_WORK, 0);
      chk("work", w, q);
      bus(1'b0, OFS_FLAGS, 0);
      chk("flags", f, q);
      bus(1'b0, OFS_THIGH, 0);
      chk("high", th, q);
      bus(1'b0, OFS_SKIP, 0);
      chk("skip", (sc << 8) + sk, q);
      bus(1'b0, OFS_DMEM + m * 4, 0);
      chk("byte", mem[m], q);
    end
    print_verdict();
  end
endmodule
